// file: core/adcs_pkg.sv
package adcs_pkg;

  // Bus and converter geometry.
  localparam int AW      = 8;
  localparam int NCH_DEF = 8;
  localparam int DW_DEF  = 10;
  localparam int CHW     = 3;

  // Register byte offsets.
  localparam logic [AW-1:0] OFF_CR   = 8'h00;
  localparam logic [AW-1:0] OFF_MR   = 8'h04;
  localparam logic [AW-1:0] OFF_CHER = 8'h10;
  localparam logic [AW-1:0] OFF_CHDR = 8'h14;
  localparam logic [AW-1:0] OFF_CHSR = 8'h18;
  localparam logic [AW-1:0] OFF_SR   = 8'h1C;
  localparam logic [AW-1:0] OFF_LAST_CONVERTED_DATA_REG = 8'h20;
  localparam logic [AW-1:0] OFF_ISR  = 8'h30;
  localparam logic [AW-1:0] OFF_ICR  = 8'h34;
  localparam logic [AW-1:0] OFF_IER  = 8'h38;
  localparam logic [AW-1:0] OFF_CDR0 = 8'h40;

  // Field positions.
  localparam int CR_START_BIT  = 0;
  localparam int MR_SLEEP_BIT  = 0;
  localparam int SR_CHANNEL_OVERRUN_FLAG_LSB   = 8;
  localparam int SR_DATA_READY_FLAG_BIT   = 16;
  localparam int SR_GENERAL_OVERRUN_FLAG_BIT  = 17;
  localparam int LAST_CONVERTED_DATA_REG_CHAN_LSB = 12;

  // Interrupt event bits.
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_GOVR  = 1;
  localparam int IRQ_OVR   = 2;
  localparam int IRQ_SLEEP = 3;
  localparam int IRQ_W     = 4;

  // Reset values.
  localparam logic [31:0]       RST_WORD = 32'h0000_0000;
  localparam logic [IRQ_W-1:0]  RST_IRQ  = 4'h0;

  // One-hot mask of a channel index.
  function automatic logic [7:0] chan_mask(input logic [CHW-1:0] idx);
    return 8'h01 << idx;
  endfunction

endpackage

// file: core/adcs_irq_if.sv
`timescale 1ns/1ps
`default_nettype none
interface adcs_irq_if;
  import adcs_pkg::*;
  logic [IRQ_W-1:0] event_set;
  logic [IRQ_W-1:0] clr;
  logic             en_we;
  logic [IRQ_W-1:0] en_wdata;
  logic [IRQ_W-1:0] status;
  logic [IRQ_W-1:0] enable;
  logic             irq;

  modport flags (output event_set, clr, en_we, en_wdata, input status, enable, irq);
  modport unit  (input event_set, clr, en_we, en_wdata, output status, enable, irq);
endinterface
`default_nettype wire

// file: core/adcs_chan_mem.sv
`timescale 1ns/1ps
`default_nettype none
module adcs_chan_mem #(
  parameter int DEPTH = 8,
  parameter int DW    = 10
) (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [DW-1:0]            wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output var  logic [DW-1:0]            rdata
);
  import adcs_pkg::*;

  logic [DW-1:0] mem [DEPTH];

  // The array holds no reset; a word read before any conversion wrote it is undefined.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read port; a same-address write shows on the following read.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

// file: core/adcs_irq.sv
`timescale 1ns/1ps
`default_nettype none
module adcs_irq (
  input  wire logic clk,
  input  wire logic nrst,
  adcs_irq_if.unit  ifc
);
  import adcs_pkg::*;

  // Sticky status: a set arriving with its clear wins, so no event is dropped.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ifc.status <= RST_IRQ;
    end else begin
      ifc.status <= (ifc.status & ~ifc.clr) | ifc.event_set;
    end
  end

  // Enable register.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ifc.enable <= RST_IRQ;
    end else if (ifc.en_we) begin
      ifc.enable <= ifc.en_wdata;
    end
  end

  // Level output while any enabled status bit is set.
  assign ifc.irq = |(ifc.status & ifc.enable);
endmodule
`default_nettype wire

// file: core/adcs_flags.sv
// Notes on behaviour
// [R1] Data-ready clears only on a last-data read, never on a channel data read.
// [R2] Last-data read meeting a conversion end sets data-ready only if data stored.
// [R3] A channel data read never blocks data-ready for another channel's new result.
// [R4] Disabling one channel never stops storing another's result or raising data-ready.
// [R5] Conversion end with data-ready set raises general overrun despite a status read.
// [R6] Status read clears general overrun unless a new overrun arrives that cycle.
// [R7] General overrun still rises when another channel's data is read that cycle.
// [R8] Conversion end with channel flag set raises its overrun, despite disables of other channels.
// [R9] Status read clears channel overruns, except one that a conversion end raises that cycle.
// [R10] Channel flag clears on its own data read or on a last-data read.
// [R11] A channel disabled during its conversion never gets its end flag raised.
// [R12] A channel data read clears only that channel's end flag.
// [R13] Sleep selected while idle takes effect at the end of the next conversion.
// [R14] Software writes sleep selection then a start command to sleep promptly.
// [R15] Reset clears every end, overrun, data-ready and general overrun flag.
// [R16] A set and a clear on one flag in one cycle resolve to set.
`timescale 1ns/1ps
`default_nettype none
module adcs_flags #(
  parameter int NCH = adcs_pkg::NCH_DEF,
  parameter int DW  = adcs_pkg::DW_DEF
) (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [adcs_pkg::AW-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output var  logic [31:0]             prdata,
  output      logic                    pready,
  output      logic                    pslverr,
  input  wire logic                    conv_end,
  input  wire logic [adcs_pkg::CHW-1:0] conv_chan,
  input  wire logic [DW-1:0]           conv_data,
  output var  logic                    conv_start,
  output var  logic [NCH-1:0]          chan_enable,
  output var  logic                    sleep_active,
  output      logic                    irq
);
  import adcs_pkg::*;

  // Elaboration check: the status word packs at most eight channels.
  if (NCH < 1 || NCH > 8 || DW < 1 || DW > LAST_CONVERTED_DATA_REG_CHAN_LSB) begin : g_bad_param
    $error("adcs_flags: NCH must be 1..8 and DW 1..12");
  end

  // Flag state.
  logic [NCH-1:0] eoc;
  logic [NCH-1:0] channel_overrun_flag;
  logic           data_ready_flag;
  logic           general_overrun_flag;
  logic           mode_sleep;
  logic [DW-1:0]  last_data;
  logic [CHW-1:0] last_chan;
  logic           ack;

  // Next values.
  logic [NCH-1:0] next_eoc;
  logic [NCH-1:0] next_channel_overrun_flag;
  logic           next_data_ready_flag;
  logic           next_general_overrun_flag;
  logic [31:0]    next_prdata;

  // APB phases: every transfer spends two access cycles.
  wire access  = psel & penable;
  wire first   = access & ~ack;
  wire done    = access & ack;
  wire rd_fx   = first & ~pwrite;
  wire wr_fx   = done & pwrite;

  // Address decode.
  wire hit_cr   = (paddr == OFF_CR);
  wire hit_mr   = (paddr == OFF_MR);
  wire hit_cher = (paddr == OFF_CHER);
  wire hit_chdr = (paddr == OFF_CHDR);
  wire hit_chsr = (paddr == OFF_CHSR);
  wire hit_sr   = (paddr == OFF_SR);
  wire hit_last_converted_data_reg = (paddr == OFF_LAST_CONVERTED_DATA_REG);
  wire hit_isr  = (paddr == OFF_ISR);
  wire hit_icr  = (paddr == OFF_ICR);
  wire hit_ier  = (paddr == OFF_IER);

  // Channel data window starts at the first data offset, one word per channel.
  wire [CHW-1:0] cdr_idx  = paddr[CHW+1:2];
  wire           cdr_win  = (paddr[AW-1:CHW+2] == OFF_CDR0[AW-1:CHW+2]) && (paddr[1:0] == 2'b00);
  wire           hit_cdr  = cdr_win && (32'(cdr_idx) < NCH);
  wire           hit_any  = hit_cr | hit_mr | hit_cher | hit_chdr | hit_chsr | hit_sr |
                            hit_last_converted_data_reg | hit_isr | hit_icr | hit_ier | hit_cdr;

  // Read side effects act once, at the first access cycle, where read data is captured.
  wire rd_sr   = rd_fx & hit_sr;
  wire rd_last_converted_data_reg = rd_fx & hit_last_converted_data_reg;
  wire rd_cdr  = rd_fx & hit_cdr;

  // Channel index masks.
  wire [7:0]     cdr_mask8  = chan_mask(cdr_idx);
  wire [7:0]     conv_mask8 = chan_mask(conv_chan);
  wire [NCH-1:0] cdr_rd_mask = rd_cdr ? cdr_mask8[NCH-1:0] : '0;

  // A disable written in this cycle affects only the channels it names.
  wire [NCH-1:0] chdr_now = (wr_fx & hit_chdr) ? pwdata[NCH-1:0] : '0;
  wire [NCH-1:0] en_eff   = chan_enable & ~chdr_now;

  // A result is stored only for a channel still enabled at its end. // [R2]
  wire           conv_ok    = 32'(conv_chan) < NCH;
  wire [NCH-1:0] conv_mask  = conv_ok ? conv_mask8[NCH-1:0] : '0;
  wire           store      = conv_end & |(conv_mask & en_eff); // [R4] [R11]
  wire [NCH-1:0] store_mask = store ? conv_mask : '0;
  wire [NCH-1:0] channel_overrun_flag_set   = store_mask & eoc; // [R8]
  wire           general_overrun_flag_set  = store & data_ready_flag; // [R5] [R7]
  wire           sleep_set  = conv_end & mode_sleep & ~sleep_active;

  // Flag next-state: each flag clears on its own read, and a set in the same cycle wins.
  always_comb begin
    next_eoc   = (eoc & ~(cdr_rd_mask | {NCH{rd_last_converted_data_reg}})) | store_mask; // [R10] [R12] [R16]
    next_channel_overrun_flag  = (channel_overrun_flag & ~{NCH{rd_sr}}) | channel_overrun_flag_set; // [R9] [R16]
    next_data_ready_flag  = (data_ready_flag & ~rd_last_converted_data_reg) | store; // [R1] [R2] [R3] [R16]
    next_general_overrun_flag = (general_overrun_flag & ~rd_sr) | general_overrun_flag_set; // [R6] [R16]
  end

  // Flag registers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      eoc                  <= '0; // [R15]
      channel_overrun_flag                 <= '0; // [R15]
      data_ready_flag      <= 1'b0; // [R15]
      general_overrun_flag <= 1'b0; // [R15]
    end else begin
      eoc                  <= next_eoc;
      channel_overrun_flag                 <= next_channel_overrun_flag;
      data_ready_flag      <= next_data_ready_flag;
      general_overrun_flag <= next_general_overrun_flag;
    end
  end

  // Last converted result and its channel.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_data <= '0;
      last_chan <= '0;
    end else if (store) begin
      last_data <= conv_data; // [R4]
      last_chan <= conv_chan;
    end
  end

  // Channel enables: set and clear registers, the set register decoded first.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chan_enable <= '0;
    end else if (wr_fx && hit_cher) begin
      chan_enable <= chan_enable | pwdata[NCH-1:0];
    end else if (wr_fx && hit_chdr) begin
      chan_enable <= chan_enable & ~pwdata[NCH-1:0];
    end
  end

  // Mode register holds the sleep selection.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_sleep <= RST_WORD[MR_SLEEP_BIT];
    end else if (wr_fx && hit_mr) begin
      mode_sleep <= pwdata[MR_SLEEP_BIT];
    end
  end

  // Start command is a one-cycle pulse toward the converter core.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= wr_fx & hit_cr & pwdata[CR_START_BIT];
    end
  end

  // Sleep is entered only at a conversion end, so an idle converter keeps running
  // until software starts one more conversion; a start or deselect wakes it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sleep_active <= 1'b0;
    end else if (!mode_sleep || conv_start) begin
      sleep_active <= 1'b0;
    end else if (sleep_set) begin
      sleep_active <= 1'b1; // [R13] [R14]
    end
  end

  // Channel result memory, read through a register.
  logic [DW-1:0] cdr_rdata;

  adcs_chan_mem #(
    .DEPTH (8),
    .DW    (DW)
  ) u_mem (
    .clk   (clk),
    .nrst  (nrst),
    .we    (store),
    .waddr (conv_chan),
    .wdata (conv_data),
    .raddr (cdr_idx),
    .rdata (cdr_rdata)
  );

  // Interrupt unit.
  adcs_irq_if irq_ifc ();

  assign irq_ifc.event_set[IRQ_DONE]  = store;
  assign irq_ifc.event_set[IRQ_GOVR]  = general_overrun_flag_set;
  assign irq_ifc.event_set[IRQ_OVR]   = |channel_overrun_flag_set;
  assign irq_ifc.event_set[IRQ_SLEEP] = sleep_set;
  assign irq_ifc.clr      = (wr_fx & hit_icr) ? pwdata[IRQ_W-1:0] : '0;
  assign irq_ifc.en_we    = wr_fx & hit_ier;
  assign irq_ifc.en_wdata = pwdata[IRQ_W-1:0];
  assign irq              = irq_ifc.irq;

  adcs_irq u_irq (
    .clk  (clk),
    .nrst (nrst),
    .ifc  (irq_ifc.unit)
  );

  // Read data mux; write-only and unmapped offsets read as zero.
  always_comb begin
    next_prdata = RST_WORD;
    if (hit_mr) begin
      next_prdata[MR_SLEEP_BIT] = mode_sleep;
    end else if (hit_chsr) begin
      next_prdata[NCH-1:0] = chan_enable;
    end else if (hit_sr) begin
      next_prdata[NCH-1:0]                        = eoc;
      next_prdata[SR_CHANNEL_OVERRUN_FLAG_LSB +: NCH]             = channel_overrun_flag;
      next_prdata[SR_DATA_READY_FLAG_BIT]                    = data_ready_flag;
      next_prdata[SR_GENERAL_OVERRUN_FLAG_BIT]                   = general_overrun_flag;
    end else if (hit_last_converted_data_reg) begin
      next_prdata[DW-1:0]                         = last_data;
      next_prdata[LAST_CONVERTED_DATA_REG_CHAN_LSB +: CHW]           = last_chan;
    end else if (hit_isr) begin
      next_prdata[IRQ_W-1:0] = irq_ifc.status;
    end else if (hit_ier) begin
      next_prdata[IRQ_W-1:0] = irq_ifc.enable;
    end else if (hit_cdr) begin
      next_prdata[DW-1:0] = cdr_rdata;
    end
  end

  // The extra access cycle exists because read data is registered at the first access cycle and presented in the second.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack <= 1'b0;
    end else begin
      ack <= first;
    end
  end

  // Read data is captured in the same cycle its side effects act, so a status or last-data value
  // software sees is exactly the one that was cleared; channel data comes through the memory read register, one cycle older.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= RST_WORD;
    end else if (rd_fx) begin
      prdata <= next_prdata;
    end
  end

  // Handshake outputs.
  assign pready  = done;
  assign pslverr = done & ~hit_any;
endmodule
`default_nettype wire

// file: dv/adcs_flags_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Judges the flag block from its pins alone; flag state is seen only through status reads.
module adcs_flags_chk #(
  parameter int NCH = adcs_pkg::NCH_DEF
) (
  input wire logic                    clk,
  input wire logic                    nrst,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [adcs_pkg::AW-1:0] paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic                    conv_end,
  input wire logic                    conv_start,
  input wire logic [NCH-1:0]          chan_enable,
  input wire logic                    sleep_active,
  input wire logic                    irq
);
  import adcs_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic sr_done;
  logic end_d;
  logic sr_clean;
  // A status read with no conversion end near it must find the overruns that the read before cleared.
  assign sr_done = psel && penable && pready && !pwrite && paddr == OFF_SR;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      end_d    <= 1'b0;
      sr_clean <= 1'b1;
    end else begin
      end_d    <= conv_end;
      sr_clean <= conv_end ? 1'b0 : (sr_done ? !end_d : sr_clean);
    end
  end
  sequence s_access;
    psel && penable && !pready ##1 psel && penable && pready;
  endsequence
  property p_one_wait;
    psel && !penable |=> s_access;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("Access phase length is wrong.");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("Error flag without ready.");
  property p_reset;
    !$past(nrst) |-> prdata == RST_WORD && !sleep_active && !irq && chan_enable == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("Outputs not clear after reset.");
  sequence s_start_wr;
    pready && pwrite && paddr == OFF_CR && pwdata[CR_START_BIT] && !pslverr;
  endsequence
  property p_start;
    s_start_wr |=> conv_start ##1 !conv_start;
  endproperty
  a_start: assert property (p_start) else $error("Start pulse missing or too long.");
  property p_start_cause;
    conv_start |-> $past(pready && pwrite && paddr == OFF_CR);
  endproperty
  a_start_cause: assert property (p_start_cause) else $error("Start pulse without a command.");
  property p_sleep_hold;
    !conv_end && !sleep_active |=> !sleep_active;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("Sleep entered without a conversion end.");
  property p_sr_clean;
    sr_done && sr_clean |-> prdata[SR_CHANNEL_OVERRUN_FLAG_LSB +: 8] == 8'h00 && !prdata[SR_GENERAL_OVERRUN_FLAG_BIT];
  endproperty
  a_sr_clean: assert property (p_sr_clean) else $error("Overrun survived a status read.");
  property p_disable;
    pready && pwrite && paddr == OFF_CHDR && !pslverr |=>
      chan_enable == ($past(chan_enable) & ~$past(pwdata[NCH-1:0]));
  endproperty
  a_disable: assert property (p_disable) else $error("Channel disable mask wrong.");
endmodule
bind adcs_flags adcs_flags_chk #(.NCH(NCH)) u_chk (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .conv_end(conv_end), .conv_start(conv_start), .chan_enable(chan_enable), .sleep_active(sleep_active),
  .irq(irq));
`default_nettype wire

// file: dv/adcs_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// Converter core: finishes a conversion of channel 0 after each start, or when the bench asks.
module adcs_conv_model #(
  parameter int LAT = 6
) (
  input  wire logic                        clk,
  input  wire logic                        conv_start,
  output var  logic                        conv_end,
  output var  logic [adcs_pkg::CHW-1:0]    conv_chan,
  output var  logic [adcs_pkg::DW_DEF-1:0] conv_data
);
  import adcs_pkg::*;
  // The result lines turn to the inverse after the pulse, so a late sample cannot match by luck.
  task automatic pulse(input int lag, input logic [CHW-1:0] ch, input logic [DW_DEF-1:0] d);
    repeat (lag) @(posedge clk);
    conv_end  <= 1'b1;
    conv_chan <= ch;
    conv_data <= d;
    @(posedge clk);
    conv_end  <= 1'b0;
    conv_chan <= ~ch;
    conv_data <= ~d;
  endtask
  // A start pulse is answered LAT + 1 cycles later.
  initial begin
    conv_end  = 1'b0;
    conv_chan = '0;
    conv_data = '0;
    forever begin
      @(posedge clk);
      if (conv_start === 1'b1) begin
        pulse(LAT, 3'h0, 10'h3C3);
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/test_adc_status_flag_logic.sv
`timescale 1ns/1ps
`default_nettype none
// Drives the flag block over APB and lines conversion ends up with register accesses.
module test_adc_status_flag_logic;
  import adcs_pkg::*;
  logic              clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic              conv_end, conv_start, sleep_active, irq, rd_err;
  logic [AW-1:0]     paddr;
  logic [31:0]       pwdata, prdata, rd_val;
  logic [CHW-1:0]    conv_chan;
  logic [DW_DEF-1:0] conv_data;
  logic [7:0]        chan_enable;
  int                errors, total_checks, cycles;
  adcs_flags dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_end(conv_end),
    .conv_chan(conv_chan), .conv_data(conv_data), .conv_start(conv_start), .chan_enable(chan_enable),
    .sleep_active(sleep_active), .irq(irq));
  adcs_conv_model model_u (.clk(clk), .conv_start(conv_start), .conv_end(conv_end), .conv_chan(conv_chan),
    .conv_data(conv_data));
  // A 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // A hang ends the run as a failure instead of stalling it.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_val = prdata;
    rd_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~wd;
    if (n >= 20) errors++;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0);
    chk(name, rd_val, exp);
  endtask
  // The conversion end lands in the cycle where the transfer acts: first access cycle of a read, second of a write.
  task automatic at_end(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [2:0] ch,
                        input logic [9:0] d);
    fork
      apb(w, a, wd);
      model_u.pulse(w ? 3 : 2, ch, d);
    join
  endtask
  task automatic conv(input logic [2:0] ch, input logic [9:0] d);
    model_u.pulse(1, ch, d);
  endtask
  task automatic clean();
    for (int c = 0; c < 4; c++) apb(1'b0, OFF_CDR0 + AW'(4 * c), 32'h0);
    apb(1'b0, OFF_LAST_CONVERTED_DATA_REG, 32'h0);
    apb(1'b0, OFF_SR, 32'h0);
    rdc(OFF_SR, 32'h0, "sr clean");
  endtask
  task automatic t_reset();
    rdc(OFF_SR, RST_WORD, "sr reset");
    rdc(OFF_LAST_CONVERTED_DATA_REG, RST_WORD, "last_converted_data_reg reset");
    rdc(8'hFC, 32'h0, "unmapped read");
    chk("unmapped error", {31'h0, rd_err}, 32'h1);
  endtask
  task automatic t_data_ready_flag();
    apb(1'b1, OFF_CHER, 32'h0000_000F);
    conv(3'h0, 10'h155);
    conv(3'h1, 10'h2AA);
    rdc(OFF_SR, 32'h0003_0003, "sr two ends");
    rdc(OFF_CDR0, 32'h0000_0155, "cdr0");
    rdc(OFF_SR, 32'h0001_0002, "sr after cdr");
    rdc(OFF_LAST_CONVERTED_DATA_REG, 32'h0000_12AA, "last_converted_data_reg");
    rdc(OFF_SR, 32'h0, "sr after last_converted_data_reg");
  endtask
  task automatic t_cdr_coin();
    at_end(1'b0, OFF_CDR0 + 8'h08, 32'h0, 3'h1, 10'h0F0);
    rdc(OFF_SR, 32'h0001_0002, "sr cdr meets end");
    at_end(1'b0, OFF_CDR0 + 8'h0C, 32'h0, 3'h0, 10'h30F);
    rdc(OFF_SR, 32'h0003_0003, "sr cdr meets overrun");
    clean();
  endtask
  task automatic t_last_converted_data_reg_coin();
    conv(3'h0, 10'h111);
    at_end(1'b0, OFF_LAST_CONVERTED_DATA_REG, 32'h0, 3'h5, 10'h222);
    chk("last_converted_data_reg data", rd_val, 32'h0000_0111);
    rdc(OFF_SR, 32'h0, "sr last_converted_data_reg disabled end");
    conv(3'h0, 10'h111);
    at_end(1'b0, OFF_LAST_CONVERTED_DATA_REG, 32'h0, 3'h3, 10'h333);
    rdc(OFF_SR, 32'h0003_0008, "sr last_converted_data_reg enabled end");
    clean();
  endtask
  task automatic t_sr_coin();
    conv(3'h0, 10'h001);
    conv(3'h0, 10'h002);
    rdc(OFF_LAST_CONVERTED_DATA_REG, 32'h0000_0002, "last_converted_data_reg second");
    at_end(1'b0, OFF_SR, 32'h0, 3'h0, 10'h003);
    chk("sr overrun", rd_val, 32'h0002_0100);
    rdc(OFF_SR, 32'h0001_0001, "sr read meets end");
    at_end(1'b0, OFF_SR, 32'h0, 3'h1, 10'h004);
    rdc(OFF_SR, 32'h0003_0003, "sr read meets overrun");
    clean();
  endtask
  task automatic t_disable();
    at_end(1'b1, OFF_CHDR, 32'h0000_0008, 3'h1, 10'h0AA);
    rdc(OFF_SR, 32'h0001_0002, "sr disable other");
    rdc(OFF_LAST_CONVERTED_DATA_REG, 32'h0000_10AA, "last_converted_data_reg disable other");
    conv(3'h1, 10'h0BB);
    at_end(1'b1, OFF_CHDR, 32'h0000_0004, 3'h1, 10'h0CC);
    rdc(OFF_SR, 32'h0003_0202, "sr disable overrun");
    chk("enable mask", {24'h0, chan_enable}, 32'h0000_0003);
    clean();
    at_end(1'b0, OFF_CDR0, 32'h0, 3'h3, 10'h3FF);
    rdc(OFF_SR, 32'h0, "sr disabled channel");
    apb(1'b1, OFF_CHER, 32'h0000_000C);
  endtask
  task automatic t_irq();
    apb(1'b1, OFF_ICR, 32'h0000_000F);
    apb(1'b1, OFF_IER, 32'h0000_0001);
    conv(3'h2, 10'h123);
    @(negedge clk);
    chk("irq raised", {31'h0, irq}, 32'h1);
    rdc(OFF_ISR, 32'h0000_0001, "isr done");
    apb(1'b1, OFF_IER, 32'h0);
    @(negedge clk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, OFF_IER, 32'h0000_0001);
    apb(1'b1, OFF_ICR, 32'h0000_0001);
    rdc(OFF_ISR, 32'h0, "isr cleared");
    chk("irq cleared", {31'h0, irq}, 32'h0);
    clean();
  endtask
  task automatic t_sleep();
    int n;
    n = 0;
    apb(1'b1, OFF_MR, 32'h0000_0001);
    repeat (8) @(posedge clk);
    chk("sleep while idle", {31'h0, sleep_active}, 32'h0);
    apb(1'b1, OFF_CR, 32'h0000_0001);
    while (sleep_active !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk("sleep after end", {31'h0, sleep_active}, 32'h1);
  endtask
  // Six cycles of reset, every scenario, then a second reset in mid-run.
  initial begin
    {nrst, psel, penable, pwrite} = 4'h0;
    paddr        = '0;
    pwdata       = '0;
    errors       = 0;
    total_checks = 0;
    cycles       = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_data_ready_flag();
    t_cdr_coin();
    t_last_converted_data_reg_coin();
    t_sr_coin();
    t_disable();
    t_irq();
    t_sleep();
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    results();
  end
endmodule
`default_nettype wire
